// ===== design/pms_select.sv
// Profile pin modulation select: maps select pins and serial lines to
// channel word indices, sweep triggers and amplitude ramp requests.
// Assumes pins are synchronous to core_clk and kept stable by the controller.
`timescale 1ns/1ps
`include "pms_consts.svh"
// Function
// RULE_01: Eight-level without ramp needs level 10, nonzero type, no ramp or sweep.
// RULE_02: With eight or sixteen levels, the unused channel type must be 00.
// RULE_03: Eight-level: pins 0-2 pick word; X10 channel 0, X11 channel 1.
// RULE_04: Sixteen-level: pins 0-3 pick word; X10 channel 0, X11 channel 1.
// RULE_05: Ramp use 01: two-level, pins 0/1 modulate, pins 2/3 ramp.
// RULE_06: Ramp use 10: eight-level on assigned channel, pin 3 ramps it.
// RULE_07: Ramp use 11: serial lines ramp, levels 2/4/16, single-line serial.
// RULE_08: Two-level serial ramping: pin 2 channel 0, pin 3 channel 1.
// RULE_09: Serial line 1 triggers, line 2 picks channel, line 3 direction.
// RULE_10: Four-level serial ramping: pins 0-1 channel 0, pins 2-3 channel 1.
// RULE_11: Sixteen-level serial ramping: line 1 ramps the assigned channel.
// RULE_12: Pin 0 is the most significant bit of the select value.
// RULE_13: Sweep start is the dedicated word, end is channel word 1.
// RULE_14: End words are MSB aligned; low unused bits are ignored.
// RULE_15: In sweep, pin 2 drives channel 0, pin 3 drives channel 1.
// RULE_16: Sweep requires sweep enable 1 and modulation level 00.
// RULE_17: Sweep type: 01 amplitude, 10 frequency, 11 phase, 00 undefined.
// RULE_18: Amplitude ramps come from unused select pins or serial lines.
// RULE_19: Word 0 is the dedicated register, words 1-15 at 0x0a-0x18.
// RULE_20: Pin ramping: low requests ramp-up, high requests ramp-down.
module pms_select #(
  parameter int WORD_W = 4
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic select_pin_0,
  input wire logic select_pin_1,
  input wire logic select_pin_2,
  input wire logic select_pin_3,
  input wire logic [2:0] serial_line,
  output logic [WORD_W-1:0] ch0_word_reg,
  output logic [WORD_W-1:0] ch1_word_reg,
  output logic [7:0] ch0_word_addr_reg,
  output logic [7:0] ch1_word_addr_reg,
  output logic [1:0] ch0_sweep_type_reg,
  output logic [1:0] ch1_sweep_type_reg,
  output logic ch0_sweep_up_reg,
  output logic ch1_sweep_up_reg,
  output logic ch0_ramp_trig_reg,
  output logic ch1_ramp_trig_reg,
  output logic ch0_ramp_down_reg,
  output logic ch1_ramp_down_reg,
  output logic serial_single_line_reg
);

  logic [7:0] global_function_reg;
  logic [7:0] ch0_function_reg;
  logic [7:0] ch1_function_reg;
  pms_pkg::pms_level_t level;
  pms_pkg::pms_ramp_t ramp_use;
  logic [2:0] pin_assignment_config;
  logic [1:0] pt0;
  logic [1:0] pt1;
  logic sw0;
  logic sw1;
  logic [3:0] pins;
  logic to_ch1;
  logic [3:0] w0_next;
  logic [3:0] w1_next;
  logic rt0_next;
  logic rt1_next;
  logic rd0_next;
  logic rd1_next;

  // Word address of a channel word; word 0 maps to no profile register
  function automatic logic [7:0] word_addr(input logic [3:0] w);
    word_addr = (w == 4'h0) ? 8'h00 : (`PMS_WORD_ADDR_BASE + {4'h0, w} - 8'h01); // RULE_19
  endfunction : word_addr

  assign level = pms_pkg::pms_level_t'(global_function_reg[`PMS_LVL_LSB +: 2]);
  assign ramp_use = pms_pkg::pms_ramp_t'(global_function_reg[`PMS_RAMP_LSB +: 2]);
  assign pin_assignment_config = global_function_reg[`PMS_PPC_LSB +: 3];
  assign pt0 = ch0_function_reg[`PMS_PTS_LSB +: 2];
  assign pt1 = ch1_function_reg[`PMS_PTS_LSB +: 2];
  assign sw0 = ch0_function_reg[`PMS_SWEEP_BIT];
  assign sw1 = ch1_function_reg[`PMS_SWEEP_BIT];
  // Pin 0 is the high bit of the select value
  assign pins = {select_pin_0, select_pin_1, select_pin_2, select_pin_3}; // RULE_12
  // Only the lowest assignment bit matters for single-channel modes
  assign to_ch1 = pin_assignment_config[0];

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      global_function_reg <= `PMS_GLOBAL_RST;
      ch0_function_reg <= `PMS_CH_RST;
      ch1_function_reg <= `PMS_CH_RST;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        `PMS_ADDR_GLOBAL: global_function_reg <= reg_wdata;
        `PMS_ADDR_CH0: ch0_function_reg <= reg_wdata;
        `PMS_ADDR_CH1: ch1_function_reg <= reg_wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
      reg_rdata <= 8'h00;
    else if (reg_rd)
    begin
      case (reg_addr)
        `PMS_ADDR_GLOBAL: reg_rdata <= global_function_reg;
        `PMS_ADDR_CH0: reg_rdata <= ch0_function_reg;
        `PMS_ADDR_CH1: reg_rdata <= ch1_function_reg;
        `PMS_ADDR_STATUS: reg_rdata <= {ch1_word_reg[3:0], ch0_word_reg[3:0]};
        default: reg_rdata <= 8'h00;
      endcase
    end
    else
      reg_rdata <= 8'h00;
  end

  // Word selection; controller keeps the mode combination legal
  always_comb
  begin
    w0_next = 4'h0;
    w1_next = 4'h0;
    rt0_next = 1'b0;
    rt1_next = 1'b0;
    rd0_next = 1'b0;
    rd1_next = 1'b0;
    case (level)
      pms_pkg::PMS_LVL_2:
      begin
        if (ramp_use == pms_pkg::PMS_RAMP_P23)
        begin
          w0_next = {3'h0, pins[3]}; // RULE_05
          w1_next = {3'h0, pins[2]}; // RULE_05
          rt0_next = 1'b1; // RULE_18
          rd0_next = pins[1]; // RULE_20
          rt1_next = 1'b1;
          rd1_next = pins[0]; // RULE_20
        end
        else
        begin
          // Sweep shares this mapping: pin 2 for channel 0, pin 3 for channel 1
          w0_next = {3'h0, pins[1]}; // RULE_08 RULE_15
          w1_next = {3'h0, pins[0]}; // RULE_08 RULE_15
          if (ramp_use == pms_pkg::PMS_RAMP_SER && serial_line[0]) // RULE_09
          begin
            rt0_next = ~serial_line[1]; // RULE_09
            rt1_next = serial_line[1];
            rd0_next = serial_line[2];
            rd1_next = serial_line[2];
          end
        end
      end
      pms_pkg::PMS_LVL_4:
      begin
        w0_next = {2'h0, pins[3:2]}; // RULE_10
        w1_next = {2'h0, pins[1:0]}; // RULE_10
        if (ramp_use == pms_pkg::PMS_RAMP_SER)
        begin
          rt0_next = serial_line[0]; // RULE_10
          rt1_next = serial_line[1]; // RULE_10
        end
      end
      pms_pkg::PMS_LVL_8:
      begin
        // Pin 3 is ignored for word choice
        if (to_ch1)
          w1_next = {1'b0, pins[3:1]}; // RULE_03
        else
          w0_next = {1'b0, pins[3:1]}; // RULE_03
        if (ramp_use == pms_pkg::PMS_RAMP_P3)
        begin
          rt0_next = ~to_ch1; // RULE_06
          rt1_next = to_ch1; // RULE_06
          rd0_next = pins[0] & ~to_ch1; // RULE_20
          rd1_next = pins[0] & to_ch1;
        end
      end
      pms_pkg::PMS_LVL_16:
      begin
        if (to_ch1)
          w1_next = pins; // RULE_04
        else
          w0_next = pins; // RULE_04
        if (ramp_use == pms_pkg::PMS_RAMP_SER)
        begin
          rt0_next = serial_line[0] & ~to_ch1; // RULE_11
          rt1_next = serial_line[0] & to_ch1; // RULE_11
        end
      end
      default: ;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      ch0_word_reg <= '0;
      ch1_word_reg <= '0;
      ch0_word_addr_reg <= 8'h00;
      ch1_word_addr_reg <= 8'h00;
    end
    else
    begin
      ch0_word_reg <= WORD_W'(w0_next);
      ch1_word_reg <= WORD_W'(w1_next);
      ch0_word_addr_reg <= word_addr(w0_next); // RULE_19
      ch1_word_addr_reg <= word_addr(w1_next); // RULE_19
    end
  end

  // Sweep: end word fixed at word 1; start is word 0 (dedicated)
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      ch0_sweep_type_reg <= 2'h0;
      ch1_sweep_type_reg <= 2'h0;
      ch0_sweep_up_reg <= 1'b0;
      ch1_sweep_up_reg <= 1'b0;
    end
    else
    begin
      ch0_sweep_type_reg <= (sw0 && level == pms_pkg::PMS_LVL_2) ? pt0 : 2'h0; // RULE_16 RULE_17
      ch1_sweep_type_reg <= (sw1 && level == pms_pkg::PMS_LVL_2) ? pt1 : 2'h0; // RULE_16 RULE_17
      ch0_sweep_up_reg <= sw0 && select_pin_2; // RULE_13 RULE_15
      ch1_sweep_up_reg <= sw1 && select_pin_3; // RULE_13 RULE_15
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      ch0_ramp_trig_reg <= 1'b0;
      ch1_ramp_trig_reg <= 1'b0;
      ch0_ramp_down_reg <= 1'b0;
      ch1_ramp_down_reg <= 1'b0;
      serial_single_line_reg <= 1'b0;
    end
    else
    begin
      ch0_ramp_trig_reg <= rt0_next;
      ch1_ramp_trig_reg <= rt1_next;
      ch0_ramp_down_reg <= rd0_next;
      ch1_ramp_down_reg <= rd1_next;
      // Serial lines are taken for ramping, so the port must stay one-bit
      serial_single_line_reg <= (ramp_use == pms_pkg::PMS_RAMP_SER); // RULE_07
    end
  end

  AST_WORD16_CH0: assert property (@(posedge core_clk) disable iff (reset) // RULE_04
    (level == pms_pkg::PMS_LVL_16 && !to_ch1 && !reg_wr) |=> ch0_word_reg == WORD_W'($past(pins)))
    else $error("sixteen-level word wrong on channel 0");
  AST_WORD8_CH1: assert property (@(posedge core_clk) disable iff (reset) // RULE_03
    (level == pms_pkg::PMS_LVL_8 && to_ch1) |=> ch1_word_reg == WORD_W'({1'b0, $past(pins[3:1])}))
    else $error("eight-level word wrong on channel 1");
  AST_MSB_ORDER: assert property (@(posedge core_clk) disable iff (reset) // RULE_12
    (level == pms_pkg::PMS_LVL_16 && !to_ch1 && pins == 4'b1110)
      |=> ch0_word_reg == WORD_W'(4'he))
    else $error("pin order not msb first");
  AST_TWO_LVL: assert property (@(posedge core_clk) disable iff (reset) // RULE_08
    (level == pms_pkg::PMS_LVL_2 && ramp_use != pms_pkg::PMS_RAMP_P23)
      |=> ch0_word_reg == WORD_W'({3'h0, $past(select_pin_2)}))
    else $error("two-level channel 0 pin wrong");
  AST_FOUR_LVL: assert property (@(posedge core_clk) disable iff (reset) // RULE_10
    (level == pms_pkg::PMS_LVL_4) |=> ch1_word_reg == WORD_W'({2'h0, $past(pins[1:0])}))
    else $error("four-level channel 1 word wrong");
  AST_SER_RAMP: assert property (@(posedge core_clk) disable iff (reset) // RULE_09
    (level == pms_pkg::PMS_LVL_2 && ramp_use == pms_pkg::PMS_RAMP_SER && serial_line == 3'b111)
      |=> ch1_ramp_trig_reg && ch1_ramp_down_reg && !ch0_ramp_trig_reg)
    else $error("serial ramp decode wrong");
  AST_PIN_RAMP: assert property (@(posedge core_clk) disable iff (reset) // RULE_20
    (level == pms_pkg::PMS_LVL_8 && ramp_use == pms_pkg::PMS_RAMP_P3 && !to_ch1)
      |=> ch0_ramp_trig_reg && ch0_ramp_down_reg == $past(select_pin_3))
    else $error("pin ramp direction wrong");
  AST_SWEEP: assert property (@(posedge core_clk) disable iff (reset) // RULE_15
    (sw1 && !reg_wr) |=> ch1_sweep_up_reg == $past(select_pin_3))
    else $error("sweep direction wrong on channel 1");
  AST_ADDR: assert property (@(posedge core_clk) disable iff (reset) // RULE_19
    (ch0_word_reg == WORD_W'(4'hf)) |-> ch0_word_addr_reg == 8'h18)
    else $error("word address map wrong");
  AST_SINGLE: assert property (@(posedge core_clk) disable iff (reset) // RULE_07
    (ramp_use == pms_pkg::PMS_RAMP_SER) |=> serial_single_line_reg)
    else $error("single-line flag missing");
  AST_P23_WORD: assert property (@(posedge core_clk) disable iff (reset) // RULE_05
    (level == pms_pkg::PMS_LVL_2 && ramp_use == pms_pkg::PMS_RAMP_P23)
      |=> ch0_word_reg == WORD_W'({3'h0, $past(select_pin_0)})
      && ch1_word_reg == WORD_W'({3'h0, $past(select_pin_1)}))
    else $error("two-level pin ramp word wrong");
  AST_P23_DIR: assert property (@(posedge core_clk) disable iff (reset) // RULE_20
    (level == pms_pkg::PMS_LVL_2 && ramp_use == pms_pkg::PMS_RAMP_P23)
      |=> ch0_ramp_trig_reg && ch1_ramp_trig_reg
      && ch0_ramp_down_reg == $past(select_pin_2)
      && ch1_ramp_down_reg == $past(select_pin_3))
    else $error("pin ramp pair direction wrong");
  AST_WORD8_CH0: assert property (@(posedge core_clk) disable iff (reset) // RULE_03
    (level == pms_pkg::PMS_LVL_8 && !to_ch1)
      |=> ch0_word_reg == WORD_W'({1'b0, $past(pins[3:1])}))
    else $error("eight-level word wrong on channel 0");
  AST_P3_CH1: assert property (@(posedge core_clk) disable iff (reset) // RULE_06
    (level == pms_pkg::PMS_LVL_8 && ramp_use == pms_pkg::PMS_RAMP_P3 && to_ch1)
      |=> ch1_ramp_trig_reg && !ch0_ramp_trig_reg && ch1_ramp_down_reg == $past(select_pin_3))
    else $error("pin ramp on channel 1 wrong");
  AST_SER4: assert property (@(posedge core_clk) disable iff (reset) // RULE_10
    (level == pms_pkg::PMS_LVL_4 && ramp_use == pms_pkg::PMS_RAMP_SER)
      |=> ch0_ramp_trig_reg == $past(serial_line[0])
      && ch1_ramp_trig_reg == $past(serial_line[1]))
    else $error("four-level serial ramp wrong");
  AST_SER16: assert property (@(posedge core_clk) disable iff (reset) // RULE_11
    (level == pms_pkg::PMS_LVL_16 && ramp_use == pms_pkg::PMS_RAMP_SER && to_ch1)
      |=> ch1_ramp_trig_reg == $past(serial_line[0]) && !ch0_ramp_trig_reg)
    else $error("sixteen-level serial ramp wrong");
  AST_SER_IDLE: assert property (@(posedge core_clk) disable iff (reset) // RULE_09
    (level == pms_pkg::PMS_LVL_2 && ramp_use == pms_pkg::PMS_RAMP_SER && !serial_line[0])
      |=> !ch0_ramp_trig_reg && !ch1_ramp_trig_reg)
    else $error("serial ramp without trigger");
  AST_SWEEP_TYPE: assert property (@(posedge core_clk) disable iff (reset) // RULE_17
    (sw0 && level == pms_pkg::PMS_LVL_2) |=> ch0_sweep_type_reg == $past(pt0))
    else $error("sweep type wrong on channel 0");
  AST_NO_SWEEP: assert property (@(posedge core_clk) disable iff (reset) // RULE_16
    (!sw0 || level != pms_pkg::PMS_LVL_2) |=> ch0_sweep_type_reg == 2'h0)
    else $error("sweep type without sweep setup");
  AST_SWEEP0: assert property (@(posedge core_clk) disable iff (reset) // RULE_15
    sw0 |=> ch0_sweep_up_reg == $past(select_pin_2))
    else $error("sweep direction wrong on channel 0");
  AST_END_WORD: assert property (@(posedge core_clk) disable iff (reset) // RULE_13
    (ch0_word_reg == WORD_W'(4'h1)) |-> ch0_word_addr_reg == `PMS_WORD_ADDR_BASE)
    else $error("sweep end word address wrong");
  AST_START_WORD: assert property (@(posedge core_clk) disable iff (reset) // RULE_13
    (ch0_word_reg == WORD_W'(4'h0)) |-> ch0_word_addr_reg == 8'h00)
    else $error("dedicated word address wrong");
  COV_16: cover property (@(posedge core_clk) level == pms_pkg::PMS_LVL_16 && to_ch1);
  COV_8R: cover property (@(posedge core_clk) ramp_use == pms_pkg::PMS_RAMP_P3 && select_pin_3);
  COV_SER: cover property (@(posedge core_clk)
    ch0_ramp_trig_reg && ramp_use == pms_pkg::PMS_RAMP_SER);
  COV_4S: cover property (@(posedge core_clk)
    level == pms_pkg::PMS_LVL_4 && ramp_use == pms_pkg::PMS_RAMP_SER);
  COV_SW: cover property (@(posedge core_clk) ch0_sweep_up_reg ##1 !ch0_sweep_up_reg);

endmodule : pms_select

// ===== design/pms_consts.svh
// Constants for the profile pin modulation select block.
// Assumes inclusion by bare name from the design directory.
`ifndef PMS_CONSTS_SVH
`define PMS_CONSTS_SVH
`define PMS_ADDR_GLOBAL 4'h0
`define PMS_ADDR_CH0 4'h1
`define PMS_ADDR_CH1 4'h2
`define PMS_ADDR_STATUS 4'h3
`define PMS_LVL_LSB 0
`define PMS_RAMP_LSB 2
`define PMS_PPC_LSB 4
`define PMS_PTS_LSB 0
`define PMS_SWEEP_BIT 2
`define PMS_GLOBAL_RST 8'h00
`define PMS_CH_RST 8'h00
`define PMS_WORD_ADDR_BASE 8'h0a
`endif

// ===== design/pms_pkg.sv
// Types for the profile pin modulation select block.
// Assumes pms_consts.svh holds offsets and field positions.
package pms_pkg;
  typedef enum logic [1:0] {
    PMS_LVL_2 = 2'b00,
    PMS_LVL_4 = 2'b01,
    PMS_LVL_8 = 2'b10,
    PMS_LVL_16 = 2'b11
  } pms_level_t;
  typedef enum logic [1:0] {
    PMS_RAMP_OFF = 2'b00,
    PMS_RAMP_P23 = 2'b01,
    PMS_RAMP_P3 = 2'b10,
    PMS_RAMP_SER = 2'b11
  } pms_ramp_t;
  typedef enum logic [1:0] {
    PMS_PT_NONE = 2'b00,
    PMS_PT_AMP = 2'b01,
    PMS_PT_FREQ = 2'b10,
    PMS_PT_PHASE = 2'b11
  } pms_ptype_t;
endpackage : pms_pkg

// ===== verification/pms_ctrl_model.sv
// Controller model: drives the profile select pins and serial lines.
// Assumes the bench writes the configuration before pins move.
`timescale 1ns/1ps
module pms_ctrl_model (
  input wire logic core_clk,
  output logic select_pin_0,
  output logic select_pin_1,
  output logic select_pin_2,
  output logic select_pin_3,
  output logic [2:0] serial_line
);
  initial
  begin
    {select_pin_0, select_pin_1, select_pin_2, select_pin_3} = 4'h0;
    serial_line = 3'h0;
  end
  // Bit 3 of the value lands on pin 0, the most significant
  task automatic drive(input logic [3:0] p, input logic [2:0] s);
    @(posedge core_clk);
    {select_pin_0, select_pin_1, select_pin_2, select_pin_3} <= p;
    serial_line <= s;
  endtask : drive
endmodule : pms_ctrl_model

// ===== verification/testbench.sv
// Bench for the profile pin modulation select block.
// Assumes the design package and constants header are compiled first.
`timescale 1ns/1ps
`include "pms_consts.svh"
module testbench;
  logic core_clk;
  logic reset;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_rdata;
  logic p0, p1, p2, p3;
  logic [2:0] ser;
  logic [3:0] w0, w1;
  logic [7:0] a0, a1;
  logic [1:0] t0, t1;
  logic up0, up1, tr0, tr1, dn0, dn1, sl;
  int n_mismatch = 0;
  int num_checks = 0;
  int cyc = 0;
  pms_select #(.WORD_W(4)) i_pms_select (.core_clk(core_clk), .reset(reset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .select_pin_0(p0), .select_pin_1(p1), .select_pin_2(p2),
    .select_pin_3(p3), .serial_line(ser), .ch0_word_reg(w0), .ch1_word_reg(w1),
    .ch0_word_addr_reg(a0), .ch1_word_addr_reg(a1), .ch0_sweep_type_reg(t0),
    .ch1_sweep_type_reg(t1), .ch0_sweep_up_reg(up0), .ch1_sweep_up_reg(up1),
    .ch0_ramp_trig_reg(tr0), .ch1_ramp_trig_reg(tr1), .ch0_ramp_down_reg(dn0),
    .ch1_ramp_down_reg(dn1), .serial_single_line_reg(sl));
  pms_ctrl_model i_pms_ctrl_model (.core_clk(core_clk), .select_pin_0(p0),
    .select_pin_1(p1), .select_pin_2(p2), .select_pin_3(p3), .serial_line(ser));
  task automatic stop_test;
    if (n_mismatch == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge core_clk);
    reg_wr <= 1'h0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge core_clk);
    reg_rd <= 1'h0;
    #1;
    chk(reg_rdata, exp);
  endtask : rd
  // Two edges: one to sample the pins, one spare for the config path
  task automatic pins(input logic [3:0] p, input logic [2:0] s);
    i_pms_ctrl_model.drive(p, s);
    repeat (2) @(posedge core_clk);
    #1;
  endtask : pins
  task automatic cfg(input logic [7:0] g, input logic [7:0] c0, input logic [7:0] c1);
    wr(`PMS_ADDR_GLOBAL, g);
    wr(`PMS_ADDR_CH0, c0);
    wr(`PMS_ADDR_CH1, c1);
  endtask : cfg
  task automatic t_regs;
    rd(`PMS_ADDR_GLOBAL, `PMS_GLOBAL_RST);
    rd(`PMS_ADDR_CH0, `PMS_CH_RST);
    wr(`PMS_ADDR_GLOBAL, 8'h5d);
    rd(`PMS_ADDR_GLOBAL, 8'h5d);
    wr(4'h7, 8'hff);
    rd(4'h7, 8'h00);
    wr(`PMS_ADDR_STATUS, 8'hff);
    rd(`PMS_ADDR_STATUS, 8'h00);
  endtask : t_regs
  task automatic t_levels;
    cfg(8'h22, 8'h01, 8'h00);
    pins(4'hf, 3'h0);
    chk({4'h0, w0}, 8'h07);
    chk(a0, 8'h10);
    cfg(8'h32, 8'h00, 8'h03);
    pins(4'he, 3'h0);
    chk({4'h0, w1}, 8'h07);
    cfg(8'h23, 8'h02, 8'h00);
    pins(4'he, 3'h0);
    chk({4'h0, w0}, 8'h0e);
    chk(a0, 8'h17);
    pins(4'hf, 3'h0);
    chk({4'h0, w0}, 8'h0f);
    chk(a0, 8'h18);
    cfg(8'h33, 8'h00, 8'h01);
    pins(4'h1, 3'h0);
    chk({4'h0, w1}, 8'h01);
  endtask : t_levels
  task automatic t_pin_ramp;
    cfg(8'h54, 8'h02, 8'h02);
    pins(4'ha, 3'h0);
    chk({w1, w0}, 8'h01);
    chk({4'h0, tr0, dn0, tr1, dn1}, 8'h0e);
    cfg(8'h2a, 8'h01, 8'h00);
    pins(4'ha, 3'h0);
    chk({4'h0, w0}, 8'h05);
    chk({6'h0, tr0, dn0}, 8'h02);
    pins(4'hb, 3'h0);
    chk({6'h0, tr0, dn0}, 8'h03);
    cfg(8'h3a, 8'h00, 8'h01);
    pins(4'hb, 3'h0);
    chk({4'h0, w1}, 8'h05);
    chk({4'h0, tr0, dn0, tr1, dn1}, 8'h03);
  endtask : t_pin_ramp
  task automatic t_ser_ramp;
    logic [2:0] s;
    cfg(8'h0c, 8'h01, 8'h01);
    for (int i = 0; i < 8; i++)
    begin
      s = i[2:0];
      pins(4'hc, s);
      chk({w1, w0}, 8'h00);
      chk({7'h0, sl}, 8'h01);
      chk({6'h0, tr0, tr1}, {6'h0, s[0] & ~s[1], s[0] & s[1]});
      if (s[0])
        chk({7'h0, s[1] ? dn1 : dn0}, {7'h0, s[2]});
    end
    pins(4'h2, 3'h0);
    chk({w1, w0}, 8'h01);
    cfg(8'h5d, 8'h02, 8'h02);
    pins(4'hd, 3'h1);
    chk({w1, w0}, 8'h13);
    chk({6'h0, tr0, tr1}, 8'h02);
    pins(4'hd, 3'h2);
    chk({6'h0, tr0, tr1}, 8'h01);
    cfg(8'h3f, 8'h00, 8'h02);
    pins(4'hd, 3'h1);
    chk({3'h0, tr1, w1}, 8'h1d);
    chk(a1, 8'h16);
  endtask : t_ser_ramp
  task automatic t_sweep;
    logic [1:0] pt;
    for (int i = 1; i < 4; i++)
    begin
      pt = i[1:0];
      cfg(8'h00, {6'h1, pt}, {6'h1, pt});
      pins(4'h2, 3'h0);
      chk({4'h0, t1, t0}, {4'h0, pt, pt});
      chk({6'h0, up0, up1}, 8'h02);
      chk(a0, 8'h0a);
      chk(a1, 8'h00);
    end
    pins(4'h1, 3'h0);
    chk({6'h0, up0, up1}, 8'h01);
    chk(a1, 8'h0a);
    chk(a0, 8'h00);
    wr(`PMS_ADDR_GLOBAL, 8'h01);
    pins(4'h2, 3'h0);
    chk({4'h0, t1, t0}, 8'h00);
  endtask : t_sweep
  initial
  begin
    core_clk = 1'h0;
    forever #50 core_clk = ~core_clk;
  end
  // Ceiling well above the two hundred or so cycles the scenarios need
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      stop_test();
    end
  end
  initial
  begin
    reset = 1'h1;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'h0;
    reg_rd = 1'h0;
    repeat (16) @(posedge core_clk);
    reset <= 1'h0;
    t_regs();
    t_levels();
    t_pin_ramp();
    t_ser_ramp();
    t_sweep();
    stop_test();
  end
endmodule : testbench
